/* File: memtest_pkg.sv */
// Purpose: shared constants for the memory pattern self-test link
// Assumes: one clock, synchronous active-high reset
// Notes:   status code layout is [15:14] kind, [13:0] row/column of a failure
package memtest_pkg;
    localparam int          DATA_W      = 16;
    localparam int          ADDR_W      = 10;
    localparam int          ROW_W       = 3;
    localparam int          COL_W       = 8;
    localparam int          DAC8_W      = 8;
    localparam logic [2:0]  ROW_MIN     = 3'h1;
    localparam logic [2:0]  ROW_MAX     = 3'h4;
    localparam logic [1:0]  KIND_WRITE  = 2'h0;
    localparam logic [1:0]  KIND_READ   = 2'h1;
    localparam logic [1:0]  KIND_PASS   = 2'h2;
    localparam logic [1:0]  KIND_ERROR  = 2'h3;
    localparam int          KIND_LSB    = 14;
    localparam int          GROUP_LEN   = 16;
    localparam logic [15:0] PAT_ONES    = 16'hffff;
    localparam logic [15:0] PAT_ALT     = 16'haaaa;
    localparam logic [13:0] LFSR_SEED   = 14'h0001;
    localparam logic [13:0] LFSR_TAPS   = 14'h2015;
    localparam int          ACK_TIMEOUT = 4000;
endpackage : memtest_pkg

/* File: memtest_if.sv */
// Purpose: link between host controller and memory-side sequencer
// Assumes: both ends on the same clock
// Notes:   start_irq is a one-cycle pulse; status_irq is one cycle per code, but a READ and an ERROR code can come back to back
interface memtest_if;
    logic        start_irq;
    logic        abort;
    logic        run_enable;
    logic [2:0]  start_row;
    logic [15:0] pattern_a;
    logic [15:0] pattern_b;
    logic        status_irq;
    logic [15:0] status_code;
    modport sequencer (input start_irq, abort, run_enable, start_row, pattern_a, pattern_b,
                       output status_irq, status_code);
    modport host      (output start_irq, abort, run_enable, start_row, pattern_a, pattern_b,
                       input status_irq, status_code);
endinterface : memtest_if

/* File: memtest_sequencer.sv */
// Purpose: memory-side pattern test sequencer with refresh and dac ramps
// Assumes: host keeps parameters stable while start_irq pulses
// Notes:   array is modelled internally; rows are slices of the address space

module memtest_sequencer #(
    parameter int DEPTH_W = memtest_pkg::ADDR_W
) (
    input  wire logic                         CORE_CLK,
    input  wire logic                         SYS_RST,
    input  wire logic                         TEST_LOADED,
    input  wire logic                         CHANNEL_SLOT_SYNC,
    input  wire logic                         FAULT_INJECT,
    memtest_if.sequencer                      link,
    output logic                              TEST_ACTIVE,
    output logic                              REFRESH_REQ,
    output logic                              SLOT_SELECT,
    output logic [15:0]                       DAC16,
    output logic [7:0]                        DAC8
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_WAIT  = 3'b001,
        ST_FETCH = 3'b010,
        ST_WRITE = 3'b011,
        ST_READ  = 3'b100
    } seq_state_t;

    localparam int NWORDS = 1 << DEPTH_W;

    // --------------------------------------------------------------
    // array storage, two slots selected by sync
    // --------------------------------------------------------------
    logic [15:0] mem_a [NWORDS];
    logic [15:0] mem_b [NWORDS];

    seq_state_t         state_q, state_d;
    logic [DEPTH_W-1:0] addr_q, addr_d;
    logic [15:0]        pat_q, pat_d;
    logic [15:0]        ramp_q, ramp_d;
    logic [15:0]        code_q, code_d;
    logic               irq_q, irq_d;
    logic [15:0]        pat_n_q, pat_n_d;
    logic               stopped_q, stopped_d;
    logic               sync_m, sync_q, slot_q;
    logic               we;
    logic [15:0]        wdata;
    logic [15:0]        rdata;
    logic [15:0]        expect_w;

    always_ff @(posedge CORE_CLK) begin
        sync_m <= CHANNEL_SLOT_SYNC;
        sync_q <= sync_m;
        slot_q <= SYS_RST ? 1'b0 : sync_q;
    end

    // odd addresses get pattern, even get complement
    assign wdata    = addr_q[0] ? pat_q : pat_n_q;
    assign expect_w = wdata;
    assign rdata    = (slot_q ? mem_b[addr_q] : mem_a[addr_q]) ^ {15'h0000, FAULT_INJECT};
    assign we       = (state_q == ST_WRITE);

    always_ff @(posedge CORE_CLK) begin
        if (we) begin
            if (slot_q) begin
                mem_b[addr_q] <= wdata;
            end else begin
                mem_a[addr_q] <= wdata;
            end
        end
    end

    // --------------------------------------------------------------
    // sequencer
    // --------------------------------------------------------------
    always_comb begin
        logic [2:0] row;
        row       = link.start_row;
        state_d   = state_q;
        addr_d    = addr_q;
        pat_d     = pat_q;
        ramp_d    = ramp_q;
        code_d    = code_q;
        irq_d     = 1'b0;
        pat_n_d   = pat_n_q;
        stopped_d = stopped_q;
        if (!link.run_enable) begin
            stopped_d = 1'b1;
        end else if (link.start_irq) begin
            stopped_d = 1'b0;
        end
        case (state_q)
            ST_IDLE: begin
                if (TEST_LOADED) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                ramp_d = ramp_q + 16'h0001;
                if (link.start_irq && link.run_enable) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                // parameters captured on the same edge that raises the acknowledge
                if (row < memtest_pkg::ROW_MIN || row > memtest_pkg::ROW_MAX) begin
                    row = memtest_pkg::ROW_MAX;
                end
                addr_d = DEPTH_W'(({3'h0, row} << (DEPTH_W - 2)) - 1);
                pat_d  = link.pattern_a;
                pat_n_d = link.pattern_b;
                code_d = {memtest_pkg::KIND_WRITE, 14'h0000};
                irq_d  = 1'b1;
                state_d = ST_WRITE;
            end
            ST_WRITE: begin
                if (addr_q == '0) begin
                    code_d  = {memtest_pkg::KIND_READ, 14'h0000};
                    irq_d   = 1'b1;
                    addr_d  = DEPTH_W'(({3'h0, link.start_row > memtest_pkg::ROW_MAX ||
                              link.start_row < memtest_pkg::ROW_MIN ? memtest_pkg::ROW_MAX :
                              link.start_row} << (DEPTH_W - 2)) - 1);
                    state_d = ST_READ;
                end else begin
                    addr_d = addr_q - 1'b1;
                end
            end
            ST_READ: begin
                if (rdata != expect_w) begin
                    // row in upper field, column in lower
                    code_d  = {memtest_pkg::KIND_ERROR, 14'(addr_q)};
                    irq_d   = 1'b1;
                    state_d = ST_WAIT;
                end else if (addr_q == '0) begin
                    code_d  = {memtest_pkg::KIND_PASS, 14'h0000};
                    irq_d   = 1'b1;
                    state_d = ST_WAIT;
                end else begin
                    addr_d = addr_q - 1'b1;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        if (link.abort) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_q     <= ST_IDLE;
            addr_q      <= '0;
            pat_q       <= 16'h0000;
            ramp_q      <= 16'h0000;
            code_q      <= 16'h0000;
            irq_q       <= 1'b0;
            pat_n_q     <= 16'h0000;
            stopped_q   <= 1'b0;
            TEST_ACTIVE <= 1'b0;
            REFRESH_REQ <= 1'b0;
            SLOT_SELECT <= 1'b0;
            DAC16       <= 16'h0000;
            DAC8        <= 8'h00;
        end else begin
            state_q     <= state_d;
            addr_q      <= addr_d;
            pat_q       <= pat_d;
            ramp_q      <= ramp_d;
            code_q      <= code_d;
            irq_q       <= irq_d;
            pat_n_q     <= pat_n_d;
            stopped_q   <= stopped_d;
            TEST_ACTIVE <= (state_d != ST_IDLE) && (state_d != ST_WAIT);
            REFRESH_REQ <= (state_d == ST_WAIT);
            SLOT_SELECT <= slot_q;
            DAC16       <= ramp_d;
            if (!stopped_d) begin
                DAC8 <= ramp_d[15:8];
            end
        end
    end

    assign link.status_irq  = irq_q;
    assign link.status_code = code_q;
endmodule : memtest_sequencer

/* File: memtest_host.sv */
// Purpose: host end that sequences pattern passes and collects status
// Assumes: same clock as the sequencer
// Notes:   lfsr is 14 bits, period 16383
module memtest_host #(
    parameter int ACK_TIMEOUT = memtest_pkg::ACK_TIMEOUT
) (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        START_PASS,
    input  wire logic        STOP_TEST,
    input  wire logic        QUIT,
    input  wire logic [2:0]  ROW_SEL,
    memtest_if.host          link,
    output logic             BUSY,
    output logic             DONE,
    output logic             PASSED,
    output logic             FAILED,
    output logic             NO_RESPONSE,
    output logic [15:0]      LAST_CODE,
    output logic [3:0]       PASS_INDEX
);
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_ACK  = 2'b01,
        H_RUN  = 2'b10
    } host_state_t;

    host_state_t state_q, state_d;
    logic [13:0] lfsr_q, lfsr_d;
    logic [15:0] tmo_q, tmo_d;
    logic [3:0]  idx_q, idx_d;
    logic [15:0] pat;
    logic        go;
    logic [1:0]  kind;

    assign kind = link.status_code[15:memtest_pkg::KIND_LSB];
    assign go   = START_PASS && state_q == H_IDLE && !STOP_TEST;

    // pattern group of sixteen passes
    always_comb begin
        case (idx_q)
            4'h0:    pat = memtest_pkg::PAT_ONES;
            4'h1:    pat = ~memtest_pkg::PAT_ONES;
            4'h2:    pat = memtest_pkg::PAT_ALT;
            4'h3:    pat = ~memtest_pkg::PAT_ALT;
            default: pat = {2'h0, lfsr_q};
        endcase
    end

    always_comb begin
        state_d = state_q;
        lfsr_d  = lfsr_q;
        tmo_d   = tmo_q;
        idx_d   = idx_q;
        case (state_q)
            H_IDLE: begin
                if (go) begin
                    state_d = H_ACK;
                    tmo_d   = 16'h0000;
                end
            end
            H_ACK: begin
                tmo_d = tmo_q + 16'h0001;
                if (link.status_irq && kind == memtest_pkg::KIND_WRITE) begin
                    state_d = H_RUN;
                end else if (tmo_q == 16'(ACK_TIMEOUT)) begin
                    state_d = H_IDLE;
                end
            end
            H_RUN: begin
                if (link.status_irq && (kind == memtest_pkg::KIND_PASS || kind == memtest_pkg::KIND_ERROR)) begin
                    state_d = H_IDLE;
                    idx_d   = idx_q + 4'h1;
                    if (idx_q >= 4'h4) begin
                        lfsr_d = {lfsr_q[12:0], ^(lfsr_q & memtest_pkg::LFSR_TAPS)};
                    end
                end
            end
            default: state_d = H_IDLE;
        endcase
        if (QUIT) begin
            state_d = H_IDLE;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_q          <= H_IDLE;
            lfsr_q           <= memtest_pkg::LFSR_SEED;
            tmo_q            <= 16'h0000;
            idx_q            <= 4'h0;
            link.start_irq   <= 1'b0;
            link.abort       <= 1'b0;
            link.run_enable  <= 1'b1;
            link.start_row   <= memtest_pkg::ROW_MAX;
            link.pattern_a   <= 16'h0000;
            link.pattern_b   <= 16'h0000;
            BUSY             <= 1'b0;
            DONE             <= 1'b0;
            PASSED           <= 1'b0;
            FAILED           <= 1'b0;
            NO_RESPONSE      <= 1'b0;
            LAST_CODE        <= 16'h0000;
            PASS_INDEX       <= 4'h0;
        end else begin
            state_q         <= state_d;
            lfsr_q          <= lfsr_d;
            tmo_q           <= tmo_d;
            idx_q           <= idx_d;
            link.start_irq  <= go;
            link.abort      <= QUIT;
            link.run_enable <= !STOP_TEST;
            if (go) begin
                if (ROW_SEL < memtest_pkg::ROW_MIN || ROW_SEL > memtest_pkg::ROW_MAX) begin
                    link.start_row <= memtest_pkg::ROW_MAX;
                end else begin
                    link.start_row <= ROW_SEL;
                end
                link.pattern_a <= pat;
                link.pattern_b <= ~pat;
            end
            BUSY        <= state_d != H_IDLE;
            DONE        <= state_q == H_RUN && state_d == H_IDLE;
            if (link.status_irq) begin
                LAST_CODE <= link.status_code;
                PASSED    <= kind == memtest_pkg::KIND_PASS;
                FAILED    <= kind == memtest_pkg::KIND_ERROR;
            end
            if (go) begin
                NO_RESPONSE <= 1'b0;
            end else if (state_q == H_ACK && state_d == H_IDLE) begin
                NO_RESPONSE <= 1'b1;
            end
            PASS_INDEX  <= idx_q;
        end
    end
endmodule : memtest_host

/* File: memtest_checker.sv */
// Purpose: link checks between host controller and memory-side sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   sees only the link signals; sized for a 32-word array
module memtest_checker (
    input wire logic        CORE_CLK,
    input wire logic        SYS_RST,
    input wire logic        start_irq,
    input wire logic        abort,
    input wire logic        run_enable,
    input wire logic [2:0]  start_row,
    input wire logic [15:0] pattern_a,
    input wire logic [15:0] pattern_b,
    input wire logic        status_irq,
    input wire logic [15:0] status_code
);
    // ----------------------------------------
    // link properties
    // ----------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);
    wire logic [1:0] kind = status_code[15:14];

    property p_status_pulse;
        status_irq ##1 status_irq |-> kind == memtest_pkg::KIND_ERROR && $past(kind) == memtest_pkg::KIND_READ;
    endproperty
    a_status_pulse: assert property (p_status_pulse) else $error("status pulse too long");
    property p_ack_write; start_irq ##2 status_irq |-> kind == memtest_pkg::KIND_WRITE; endproperty
    a_ack_write: assert property (p_ack_write) else $error("start not acknowledged by writing code");
    property p_write_gap; status_irq && kind == memtest_pkg::KIND_WRITE |=> !status_irq [*7]; endproperty
    a_write_gap: assert property (p_write_gap) else $error("reading code before write phase ended");
    property p_read_follows;
        disable iff (SYS_RST || abort)
        status_irq && kind == memtest_pkg::KIND_WRITE |-> ##[8:60] status_irq && kind == memtest_pkg::KIND_READ;
    endproperty
    a_read_follows: assert property (p_read_follows) else $error("no reading code after write phase");
    property p_verdict;
        disable iff (SYS_RST || abort)
        status_irq && kind == memtest_pkg::KIND_READ |-> ##[1:60] status_irq && kind[1];
    endproperty
    a_verdict: assert property (p_verdict) else $error("no verdict after read phase");
    property p_err_addr; status_irq && kind == memtest_pkg::KIND_ERROR |-> status_code[13:5] == 9'h000; endproperty
    a_err_addr: assert property (p_err_addr) else $error("error location outside array");
    property p_code_hold; $changed(status_code) |-> status_irq; endproperty
    a_code_hold: assert property (p_code_hold) else $error("status code changed without interrupt");
    property p_start_row;
        start_irq |-> run_enable && start_row >= memtest_pkg::ROW_MIN && start_row <= memtest_pkg::ROW_MAX;
    endproperty
    a_start_row: assert property (p_start_row) else $error("start with bad row or while stopped");
    property p_complement; start_irq |-> pattern_b == ~pattern_a; endproperty
    a_complement: assert property (p_complement) else $error("pattern words not complementary");
    property p_one_pass; start_irq |=> !start_irq [*8]; endproperty
    a_one_pass: assert property (p_one_pass) else $error("second start inside a pass");
endmodule : memtest_checker

/* File: tb_dram_pattern_test_sequencer.sv */
// Purpose: self-checking bench for host and sequencer joined by the link
// Assumes: 25 MHz clock, reset held 16 cycles
// Notes:   array shrunk to 32 words, host timeout shrunk to 50 cycles
module tb_dram_pattern_test_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, sys_rst = 1'b1, test_loaded = 1'b1, slot_sync = 1'b0;
    logic        fault_inject = 1'b0, start_pass = 1'b0, stop_test = 1'b0, quit = 1'b0;
    logic [2:0]  row_sel = 3'h1;
    logic        test_active, refresh_req, slot_select, busy, done, passed, failed, no_response;
    logic [15:0] dac16, last_code, prev_dac;
    logic [7:0]  dac8;
    logic [3:0]  pass_index;
    logic        was_active = 1'b0;
    int          failures = 0, samples_checked = 0, cycles = 0, irq_count = 0;
    logic [15:0] pats[$];

    always #20 core_clk = ~core_clk;
    memtest_if memtest_if_i ();
    memtest_sequencer #(.DEPTH_W(5)) memtest_sequencer_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .TEST_LOADED(test_loaded), .CHANNEL_SLOT_SYNC(slot_sync), .FAULT_INJECT(fault_inject),
        .link(memtest_if_i.sequencer), .TEST_ACTIVE(test_active), .REFRESH_REQ(refresh_req),
        .SLOT_SELECT(slot_select), .DAC16(dac16), .DAC8(dac8));
    memtest_host #(.ACK_TIMEOUT(50)) memtest_host_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .START_PASS(start_pass), .STOP_TEST(stop_test), .QUIT(quit), .ROW_SEL(row_sel),
        .link(memtest_if_i.host), .BUSY(busy), .DONE(done), .PASSED(passed), .FAILED(failed),
        .NO_RESPONSE(no_response), .LAST_CODE(last_code), .PASS_INDEX(pass_index));
    memtest_checker memtest_checker_i (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .start_irq(memtest_if_i.start_irq), .abort(memtest_if_i.abort),
        .run_enable(memtest_if_i.run_enable), .start_row(memtest_if_i.start_row),
        .pattern_a(memtest_if_i.pattern_a), .pattern_b(memtest_if_i.pattern_b),
        .status_irq(memtest_if_i.status_irq), .status_code(memtest_if_i.status_code));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic wrap_up;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    // one start pulse, optional stop mid-pass, bounded wait for the verdict
    task automatic run_pass(input logic [2:0] row, input logic stop, input logic [15:0] kind);
        int k;
        int irq0;
        k = 0;
        irq0 = irq_count;
        row_sel <= row;
        start_pass <= 1'b1;
        tick(1);
        start_pass <= 1'b0;
        stop_test <= stop;
        tick(1);
        k = 1;
        cmp(16'(busy), 16'h1);
        while (done !== 1'b1 && k < 400) begin
            tick(1);
            k++;
        end
        cmp(16'(k < 400), 16'h1);
        cmp(16'(busy), 16'h0);
        cmp(16'(last_code[15:14]), 16'(kind));
        cmp(16'(irq_count - irq0), 16'h3);
    endtask : run_pass

    // ----------------------------------------
    // monitor and timeout
    // ----------------------------------------
    always @(posedge core_clk) begin
        cycles++;
        if (memtest_if_i.status_irq === 1'b1) irq_count++;
        if (memtest_if_i.start_irq === 1'b1) pats.push_back(memtest_if_i.pattern_a);
        if (!sys_rst && was_active && test_active === 1'b1) cmp(dac16, prev_dac);
        was_active = (test_active === 1'b1);
        prev_dac = dac16;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_slot;
        for (int v = 0; v < 2; v++) begin
            slot_sync <= v[0];
            tick(6);
            cmp(16'(slot_select), 16'(v));
        end
    endtask : t_slot

    task automatic t_ramp;
        logic [15:0] a;
        logic [7:0]  b;
        a = dac16;
        b = dac8;
        tick(10);
        cmp(dac16, a + 16'h000a);
        cmp(16'(refresh_req), 16'h1);
        tick(260);
        cmp(16'(dac8 !== b), 16'h1);
    endtask : t_ramp

    task automatic t_group;
        for (int p = 0; p < 17; p++) run_pass(3'h1, 1'b0, 16'(memtest_pkg::KIND_PASS));
        tick(1);
        cmp(16'(pass_index), 16'h1);
        cmp(pats[0], memtest_pkg::PAT_ONES);
        cmp(pats[1], 16'h0000);
        cmp(pats[2], memtest_pkg::PAT_ALT);
        cmp(pats[3], ~memtest_pkg::PAT_ALT);
        cmp(pats[16], pats[0]);
    endtask : t_group

    task automatic t_rows;
        for (int r = 1; r <= 4; r++) run_pass(3'(r), 1'b0, 16'(memtest_pkg::KIND_PASS));
        run_pass(3'h0, 1'b0, 16'(memtest_pkg::KIND_PASS));
        cmp(16'(passed), 16'h1);
    endtask : t_rows

    task automatic t_fault;
        fault_inject <= 1'b1;
        run_pass(3'h2, 1'b0, 16'(memtest_pkg::KIND_ERROR));
        cmp(16'(failed), 16'h1);
        cmp(16'(last_code[13:4]), 16'h0);
        cmp(16'(last_code[13:0]), 16'h000f);
        fault_inject <= 1'b0;
    endtask : t_fault

    task automatic t_stop;
        logic [15:0] a;
        logic [7:0]  b;
        run_pass(3'h4, 1'b1, 16'(memtest_pkg::KIND_PASS));
        tick(4);
        a = dac16;
        b = dac8;
        tick(300);
        cmp(16'(dac8), 16'(b));
        cmp(dac16, a + 16'h012c);
        stop_test <= 1'b0;
        tick(2);
    endtask : t_stop

    task automatic t_quit;
        int k;
        k = 0;
        row_sel <= 3'h4;
        start_pass <= 1'b1;
        tick(1);
        start_pass <= 1'b0;
        tick(6);
        cmp(16'(test_active), 16'h1);
        quit <= 1'b1;
        test_loaded <= 1'b0;
        tick(4);
        cmp(16'(test_active), 16'h0);
        quit <= 1'b0;
        tick(2);
        start_pass <= 1'b1;
        tick(1);
        start_pass <= 1'b0;
        while (no_response !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        cmp(16'(no_response), 16'h1);
        test_loaded <= 1'b1;
        tick(4);
        run_pass(3'h1, 1'b0, 16'(memtest_pkg::KIND_PASS));
    endtask : t_quit

    initial begin
        tick(16);
        sys_rst <= 1'b0;
        tick(4);
        t_slot();
        t_ramp();
        t_group();
        t_rows();
        t_fault();
        t_stop();
        t_quit();
        wrap_up();
    end
endmodule : tb_dram_pattern_test_sequencer
